/* core/qrb_pkg.sv */
// Constants and types shared by the burst memory port and its storage array
package qrb_pkg;

  // ****************************************
  // Widths and burst geometry
  // ****************************************
  localparam int DATA_W   = 18;               // Narrow word width
  localparam int ADDR_W   = 6;                // Burst address width (storage depth)
  localparam int BEAT_W   = 2;                // Beat index within a burst
  localparam int BEATS    = 4;                // Words per burst
  localparam int WORD_W   = ADDR_W + BEAT_W;  // Word address width
  localparam int MEM_WORDS = 1 << WORD_W;     // Storage depth in words

  // ****************************************
  // Read latency, counted in data edges (half cycles of the link clock)
  // ****************************************
  localparam int LAT_LONG_EDGES  = 5;         // 2.5 cycles
  localparam int LAT_SHORT_EDGES = 2;         // 1 cycle
  localparam int LINE_LEN        = LAT_LONG_EDGES;

  // ****************************************
  // Reset values and small codes
  // ****************************************
  localparam logic [BEAT_W-1:0] LAST_LEFT   = 2'h3;  // Beats left after the first one
  localparam logic [2:0]        WR_BEATS    = 3'h4;  // Write beats to collect
  localparam logic [2:0]        SINCE_MAX   = 3'h7;  // Saturation of edge counter
  localparam logic [BEAT_W-1:0] FIRST_BEAT  = 2'h0;

  // Address slot served by the next rising edge of the true clock
  typedef enum logic {QRB_SLOT_READ, QRB_SLOT_WRITE} qrb_slot_t;

  // One stage of the read latency line
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } qrb_line_t;

endpackage : qrb_pkg

/* core/qrb_mem_if.sv */
// Interface between the port logic and its storage array
`timescale 1ns/1ps
interface qrb_mem_if;
  import qrb_pkg::*;
  logic              we;     // Write strobe
  logic [WORD_W-1:0] waddr;  // Write word address
  logic [DATA_W-1:0] wdata;  // Write word
  logic [WORD_W-1:0] raddr;  // Read word address
  logic [DATA_W-1:0] rdata;  // Registered read word

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : qrb_mem_if

/* core/qrb_mem.sv */
// Storage array with one write port and one registered read port
`timescale 1ns/1ps
module qrb_mem
  import qrb_pkg::*;
(
  // Clock
  input  wire logic clk_i,
  // Array access
  qrb_mem_if.mem    mif
);

  logic [DATA_W-1:0] ram [MEM_WORDS];

  // ****************************************
  // Array write and registered read
  // ****************************************
  // Read shows the word before a same-clock write; the port spaces them apart
  always_ff @(posedge clk_i) begin
    if (mif.we) begin
      ram[mif.waddr] <= mif.wdata;
    end
    mif.rdata <= ram[mif.raddr];
  end

endmodule : qrb_mem

/* core/qrb_port.sv */
// Burst memory port: shared address bus, double-rate read and write data, echo clocks
`timescale 1ns/1ps

// Operation
// - Read and write ports run independently
// - One shared bus carries both addresses
// - Read and write address slots alternate
// - Each address moves four sequential words
// - Data moves on both clocks' rising edges
// - Mode high gives 2.5 cycle read latency
// - Mode low gives one cycle read latency
// - Valid output marks read data present
// - Echo clock pair accompanies read data
// - Separate select per port for expansion
// - Inputs are registered before use
// - Data outputs launch from registers
// - Array writes complete self-timed internally
// - Reads return newest data, bypassing writes
module qrb_port
  import qrb_pkg::*;
(
  // System
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // Link clocks
  input  wire logic              k_clk_i,
  input  wire logic              k_clk_n_i,
  // Address and selects
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              rd_sel_n_i,
  input  wire logic              wr_sel_n_i,
  input  wire logic              latency_mode_select_i,
  // Write data
  input  wire logic [DATA_W-1:0] write_data_i,
  // Read data and echo clocks
  output logic      [DATA_W-1:0] read_data_o,
  output logic                   read_data_valid_o,
  output logic                   echo_clock_out_o,
  output logic                   echo_clock_out_n_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic                             k1, k2, k3;     // True clock sampler
    logic                             kn1, kn2, kn3;  // Complement clock sampler
    logic [ADDR_W-1:0]                addr1, addr2;
    logic                             rsel1, rsel2;
    logic                             wsel1, wsel2;
    logic                             mode1, mode2;
    logic [DATA_W-1:0]                wd1, wd2;
    qrb_slot_t                        slot;           // Slot of next true edge
    qrb_line_t [LINE_LEN-1:0]         line;           // Read latency line
    logic [ADDR_W-1:0]                ptr_addr;       // Word to show next
    logic [BEAT_W-1:0]                ptr_beat;
    logic [BEAT_W-1:0]                beats_left;
    logic                             rd_valid;
    logic [DATA_W-1:0]                rdata;
    logic                             echo, echo_n;
    logic [ADDR_W-1:0]                wr_addr;
    logic [BEAT_W-1:0]                wr_beat;
    logic [2:0]                       wr_left;
    logic                             we;
    logic [WORD_W-1:0]                waddr;
    logic [DATA_W-1:0]                wdata;
  } qrb_state_t;

  qrb_state_t s;
  qrb_state_t next_s;

  qrb_mem_if mif ();

  // Rising edge of a sampled level
  function automatic logic qrb_rise(input logic now_lvl, input logic old_lvl);
    return now_lvl & ~old_lvl;
  endfunction : qrb_rise

  // Reset image: the complement clock idles high, so its samplers start high
  // and no false edge is seen right after reset
  function automatic qrb_state_t qrb_reset_state();
    qrb_state_t r;
    r     = '0;
    r.kn1 = 1'b1;
    r.kn2 = 1'b1;
    r.kn3 = 1'b1;
    return r;
  endfunction : qrb_reset_state

  // ****************************************
  // Edge and hazard decode
  // ****************************************
  logic   k_rise;
  logic   kn_rise;
  logic   edge_any;
  int     lat_idx;
  logic   start;
  logic   wr_cap;
  logic   hit;
  logic   rd_out;

  // Data edges of both link clocks
  assign k_rise   = qrb_rise(s.k2, s.k3);
  assign kn_rise  = qrb_rise(s.kn2, s.kn3);
  assign edge_any = k_rise | kn_rise;
  // Latency stage picked by the mode pin
  assign lat_idx  = s.mode2 ? LAT_LONG_EDGES - 1 : LAT_SHORT_EDGES - 1;
  assign start    = edge_any & s.line[lat_idx].valid;
  assign rd_out   = edge_any & (start | (s.beats_left != '0));
  assign wr_cap   = edge_any & (s.wr_left != '0);
  // Write beat landing on the word being shown
  assign hit      = wr_cap & ({s.wr_addr, s.wr_beat} == {s.ptr_addr, s.ptr_beat});

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s = s;
    // Input registers: two stages before any logic reads them
    next_s.k1    = k_clk_i;
    next_s.k2    = s.k1;
    next_s.k3    = s.k2;
    next_s.kn1   = k_clk_n_i;
    next_s.kn2   = s.kn1;
    next_s.kn3   = s.kn2;
    next_s.addr1 = addr_i;
    next_s.addr2 = s.addr1;
    next_s.rsel1 = rd_sel_n_i;
    next_s.rsel2 = s.rsel1;
    next_s.wsel1 = wr_sel_n_i;
    next_s.wsel2 = s.wsel1;
    next_s.mode1 = latency_mode_select_i;
    next_s.mode2 = s.mode1;
    next_s.wd1   = write_data_i;
    next_s.wd2   = s.wd1;
    // Echo clocks follow the sampled link clocks
    next_s.echo   = s.k2;
    next_s.echo_n = s.kn2;
    next_s.we     = 1'b0;
    if (edge_any) begin
      // Write beat capture, committed to the array without further timing
      if (wr_cap) begin
        next_s.we      = 1'b1;
        next_s.waddr   = {s.wr_addr, s.wr_beat};
        next_s.wdata   = s.wd2;
        next_s.wr_beat = s.wr_beat + 1'b1;
        next_s.wr_left = s.wr_left - 3'h1;
      end
      // Read beat launch, independent of the write side
      if (start) begin
        next_s.rd_valid   = 1'b1;
        next_s.beats_left = LAST_LEFT;
      end else if (s.beats_left != '0) begin
        next_s.beats_left = s.beats_left - 1'b1;
      end else begin
        next_s.rd_valid   = 1'b0;
      end
      if (rd_out) begin
        next_s.rdata = hit ? s.wd2 : mif.rdata;
      end
      // Latency line advances one stage per data edge
      next_s.line[0] = '0;
      for (int i = 1; i < LINE_LEN; i++) begin
        next_s.line[i] = s.line[i-1];
      end
      // Address slots alternate on the true clock
      if (k_rise) begin
        case (s.slot)
          QRB_SLOT_READ: begin
            if (!s.rsel2) begin
              next_s.line[0] = '{valid: 1'b1, addr: s.addr2};
            end
            next_s.slot = QRB_SLOT_WRITE;
          end
          QRB_SLOT_WRITE: begin
            if (!s.wsel2) begin
              next_s.wr_addr = s.addr2;
              next_s.wr_beat = FIRST_BEAT;
              next_s.wr_left = WR_BEATS;
            end
            next_s.slot = QRB_SLOT_READ;
          end
          default: begin
            next_s.slot = QRB_SLOT_READ;
          end
        endcase
      end
      // Point the array at the word due on the next edge
      if (next_s.line[lat_idx].valid) begin
        next_s.ptr_addr = next_s.line[lat_idx].addr;
        next_s.ptr_beat = FIRST_BEAT;
      end else begin
        next_s.ptr_beat = s.ptr_beat + 1'b1;
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s <= qrb_reset_state();
    end else begin
      s <= next_s;
    end
  end

  // Array hookup
  assign mif.we    = s.we;
  assign mif.waddr = s.waddr;
  assign mif.wdata = s.wdata;
  assign mif.raddr = {s.ptr_addr, s.ptr_beat};

  qrb_mem u_mem (
    .clk_i (clk_i),
    .mif   (mif.mem)
  );

  // Outputs straight from state flops
  assign read_data_o        = s.rdata;
  assign read_data_valid_o  = s.rd_valid;
  assign echo_clock_out_o   = s.echo;
  assign echo_clock_out_n_o = s.echo_n;

  // ****************************************
  // Checks
  // ****************************************
  logic [2:0] since_acc;

  // Data edges since the last accepted read
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      since_acc <= SINCE_MAX;
    end else if (k_rise && s.slot == QRB_SLOT_READ && !s.rsel2) begin
      since_acc <= '0;
    end else if (edge_any && since_acc != SINCE_MAX) begin
      since_acc <= since_acc + 3'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_last_beat;
    edge_any && s.rd_valid && s.beats_left == '0 && !start;
  endsequence

  sequence s_read_slot_idle;
    k_rise && s.slot == QRB_SLOT_READ && s.rsel2;
  endsequence

  // Accepted read: select low in a read slot
  sequence s_read_accept;
    k_rise && s.slot == QRB_SLOT_READ && !s.rsel2;
  endsequence

  // Accepted write: select low in a write slot
  sequence s_write_accept;
    k_rise && s.slot == QRB_SLOT_WRITE && !s.wsel2;
  endsequence

  sequence s_write_slot_idle;
    k_rise && s.slot == QRB_SLOT_WRITE && s.wsel2;
  endsequence

  a_valid_on_start: assert property (start |=> read_data_valid_o)
    else $error("valid not raised at burst start");
  a_valid_four_beats: assert property (s_last_beat |=> !read_data_valid_o)
    else $error("valid held past the fourth beat");
  a_lat_short_mode: assert property (start && !s.mode2 |-> since_acc == 3'h1)
    else $error("short latency burst at wrong edge");
  a_lat_long_mode: assert property (start && s.mode2 |-> (since_acc == 3'h4 || since_acc == 3'h0))
    else $error("long latency burst at wrong edge");
  a_slot_alternates: assert property (k_rise |=> s.slot != $past(s.slot))
    else $error("address slot did not alternate");
  a_idle_select_read: assert property (s_read_slot_idle |=> !s.line[0].valid)
    else $error("read started with select high");
  a_self_timed_write: assert property (wr_cap |=> mif.we && mif.waddr == $past({s.wr_addr, s.wr_beat}))
    else $error("captured write beat not committed");
  a_bypass_newest: assert property (rd_out && hit |=> read_data_o == $past(s.wd2))
    else $error("read missed in-flight write data");
  a_out_hold_data: assert property (!edge_any |=> $stable(read_data_o))
    else $error("read data changed between edges");
  a_echo_follow: assert property ($rose(s.k2) |=> echo_clock_out_o)
    else $error("echo clock did not follow");
  // Slot capture, burst length and output holding
  a_read_take_addr: assert property (s_read_accept |=> s.line[0].valid && s.line[0].addr == $past(s.addr2))
    else $error("read address not taken in its slot");
  a_write_take_addr: assert property (s_write_accept |=> s.wr_addr == $past(s.addr2) && s.wr_left == WR_BEATS)
    else $error("write address or beat count not taken");
  a_idle_select_write: assert property (s_write_slot_idle |=> $stable(s.wr_addr))
    else $error("write started with select high");
  a_valid_mid_burst: assert property (edge_any && s.beats_left != '0 |=> read_data_valid_o)
    else $error("valid dropped inside a burst");
  a_valid_hold_idle: assert property (!edge_any |=> $stable(read_data_valid_o))
    else $error("valid changed between edges");
  a_data_from_array: assert property (rd_out && !hit |=> read_data_o == $past(mif.rdata))
    else $error("read beat not taken from the array");
  a_echo_n_follow: assert property ($rose(s.kn2) |=> echo_clock_out_n_o)
    else $error("complement echo clock did not follow");
  a_no_stray_write: assert property (!wr_cap |=> !mif.we)
    else $error("array written without a captured beat");

endmodule : qrb_port

/* verif/qrb_ctl_model.sv */
// Memory controller model: link clocks, shared address, selects and write beats
`timescale 1ns/1ps
module qrb_ctl_model
  import qrb_pkg::*;
(
  // Link clocks
  output logic              k_clk_o,
  output logic              k_clk_n_o,
  // Address, selects and write data
  output logic [ADDR_W-1:0] addr_o,
  output logic              rd_sel_n_o,
  output logic              wr_sel_n_o,
  output logic [DATA_W-1:0] write_data_o
);
  int                  ecnt;     // Link rising edges so far
  int                  wleft;    // Write beats still to drive
  bit                  go;       // Starts the link clocks
  bit                  rd_slot;  // Next true rise is a read slot
  int                  re_q[$];  // Edges where reads were taken
  logic [ADDR_W-1:0]   rd_q[$];
  logic [ADDR_W-1:0]   wa_q[$];
  logic [4*DATA_W-1:0] wd_q[$];
  logic [4*DATA_W-1:0] wbuf;

  // Sets up the pins ahead of the next link edge, half an edge early
  task automatic prep(input bit t);
    if (wleft > 0) begin
      write_data_o = wbuf[DATA_W-1:0];
      wbuf = wbuf >> DATA_W;
      wleft--;
    end else begin
      write_data_o = ~write_data_o;
    end
    addr_o = ~addr_o;
    rd_sel_n_o = 1'b1;
    wr_sel_n_o = 1'b1;
    if (t) begin
      if (rd_slot && rd_q.size() > 0) begin
        addr_o = rd_q.pop_front();
        rd_sel_n_o = 1'b0;
        re_q.push_back(ecnt + 1);
      end else if (!rd_slot && wa_q.size() > 0) begin
        addr_o = wa_q.pop_front();
        wbuf = wd_q.pop_front();
        wr_sel_n_o = 1'b0;
        wleft = BEATS;
      end
      rd_slot = !rd_slot;
    end
  endtask : prep

  // Link clock pair, 800 ns period, rising edges of both carry data
  initial begin
    k_clk_o = 1'b0;
    k_clk_n_o = 1'b1;
    addr_o = '0;
    rd_sel_n_o = 1'b1;
    wr_sel_n_o = 1'b1;
    write_data_o = '0;
    rd_slot = 1'b1;
    wait (go);
    forever begin
      prep(1'b1);
      #200 k_clk_o = 1'b1;
      k_clk_n_o = 1'b0;
      ecnt++;
      #200 prep(1'b0);
      #200 k_clk_o = 1'b0;
      k_clk_n_o = 1'b1;
      ecnt++;
      #200;
    end
  end
endmodule : qrb_ctl_model

/* verif/quad_rate_burst_sram_port_tb_top.sv */
// Testbench for the burst memory port
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
module quad_rate_burst_sram_port_tb_top;
  import qrb_pkg::*;
  logic              clk_i, rstn_i, k_clk, k_clk_n, rd_sel_n, wr_sel_n, mode, vld, eco, eco_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdat, rdat;
  logic [DATA_W:0]   seen [0:8191];
  int                errors, checked;

  qrb_port dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .k_clk_i(k_clk), .k_clk_n_i(k_clk_n), .addr_i(addr),
    .rd_sel_n_i(rd_sel_n), .wr_sel_n_i(wr_sel_n), .latency_mode_select_i(mode), .write_data_i(wdat),
    .read_data_o(rdat), .read_data_valid_o(vld), .echo_clock_out_o(eco), .echo_clock_out_n_o(eco_n));
  qrb_ctl_model ctl_u (.k_clk_o(k_clk), .k_clk_n_o(k_clk_n), .addr_o(addr), .rd_sel_n_o(rd_sel_n),
    .wr_sel_n_o(wr_sel_n), .write_data_o(wdat));

  // Records valid and data mid-beat for every link edge
  always @(posedge k_clk or posedge k_clk_n) if (ctl_u.go) fork
    begin
      #600 seen[ctl_u.ecnt-1] = {vld, rdat};
      `CHK("echo", {~ctl_u.ecnt[0], ctl_u.ecnt[0]}, {eco, eco_n})
    end
  join_none

  function automatic logic [DATA_W-1:0] wv(input logic [ADDR_W-1:0] a, input int b, input logic [9:0] s);
    return {s, 2'(b), a};
  endfunction : wv

  function automatic logic [4*DATA_W-1:0] burst(input logic [ADDR_W-1:0] a, input logic [9:0] s);
    return {wv(a, 3, s), wv(a, 2, s), wv(a, 1, s), wv(a, 0, s)};
  endfunction : burst

  // Judges one read burst: latency, four valid beats, data per word
  task automatic chk_read(input logic [ADDR_W-1:0] a, input logic [9:0] s, input int lat, input bit pre,
                          input bit post);
    int e;
    wait (ctl_u.re_q.size() > 0);
    e = ctl_u.re_q.pop_front() + lat;
    wait (ctl_u.ecnt > e + 6);
    if (pre) `CHK("early valid", 1'b0, seen[e-1][DATA_W])
    for (int k = 0; k < 4; k++) begin
      `CHK("valid", 1'b1, seen[e+k][DATA_W])
      `CHK("data", wv(a, k, s), seen[e+k][DATA_W-1:0])
    end
    if (post) `CHK("late valid", 1'b0, seen[e+4][DATA_W])
  endtask : chk_read

  // Write then read at once in one latency mode
  task automatic t_mode(input logic m, input logic [ADDR_W-1:0] a, input logic [9:0] s);
    @(posedge clk_i);
    #1 mode = m;
    repeat (20) @(posedge clk_i);
    ctl_u.wa_q.push_back(a);
    ctl_u.wd_q.push_back(burst(a, s));
    wait (ctl_u.wa_q.size() == 0);
    ctl_u.rd_q.push_back(a);
    chk_read(a, s, m ? LAT_LONG_EDGES : LAT_SHORT_EDGES, 1'b1, 1'b1);
    $display("test mode %0d done", m);
  endtask : t_mode

  // Back-to-back reads alongside a write, then read the new burst
  task automatic t_conc;
    ctl_u.rd_q.push_back(6'h05);
    ctl_u.rd_q.push_back(6'h3f);
    ctl_u.wa_q.push_back(6'h20);
    ctl_u.wd_q.push_back(burst(6'h20, 10'h155));
    chk_read(6'h05, 10'h0a1, LAT_LONG_EDGES, 1'b1, 1'b0);
    chk_read(6'h3f, 10'h2c3, LAT_LONG_EDGES, 1'b0, 1'b1);
    ctl_u.rd_q.push_back(6'h20);
    chk_read(6'h20, 10'h155, LAT_LONG_EDGES, 1'b1, 1'b1);
    $display("test concurrent done");
  endtask : t_conc

  task automatic complete_run;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // Clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Main sequence
  initial begin
    rstn_i = 1'b0;
    mode = 1'b0;
    repeat (20) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    repeat (5) @(posedge clk_i);
    #1 ctl_u.go = 1'b1;
    t_mode(1'b0, 6'h05, 10'h0a1);
    t_mode(1'b1, 6'h3f, 10'h2c3);
    t_conc();
    complete_run();
  end

  // Watchdog, far beyond the fewer than one hundred link edges needed
  initial begin
    #3_000_000;
    errors++;
    complete_run();
  end
endmodule : quad_rate_burst_sram_port_tb_top
